// >>> bench/dcei_top_bench.sv
// self-checking bench for the dma channel event and irq slice
`timescale 1ns/1ns
module dcei_top_bench;
	import dcei_pkg::*;
	logic          clk = 1'b0;
	logic          rst_n = 1'b0;
	logic          ce = 1'b1;
	dcei_apb_req_t apb = '0;
	dcei_xfer_in_t xfer;
	logic          pready, pslverr, start, abort, busy, chan_on, irq_line;
	logic [31:0]   prdata, src_start, dst_start, rd;
	logic          err;
	int            fail_count = 0, tests_run = 0, starts = 0, aborts = 0;
	logic [7:0]    fexp [0:8] = '{8'h01, 8'h08, 8'h04, 8'h88, 8'h10,
		8'h28, 8'h40, 8'h80, 8'h28};

	// ****************************************************************
	// harness
	// ****************************************************************
	always #4 clk = ~clk;
	always @(posedge clk)
	begin
		if (start === 1'b1) starts++;
		if (abort === 1'b1) aborts++;
	end

	dcei_top dcei_top_inst (.REF_CLK_IN(clk), .RSTN_IN(rst_n),
		.CE_IN(ce), .APB_REQ_IN(apb), .PREADY_OUT(pready),
		.PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr), .XFER_IN(xfer),
		.START_OUT(start), .ABORT_OUT(abort), .BUSY_OUT(busy),
		.CHANNEL_ON_OUT(chan_on), .IRQ_OUT(irq_line),
		.SRC_START_OUT(src_start), .DST_START_OUT(dst_start));
	dcei_xfer_model dcei_xfer_model_inst (.clk_in(clk), .xfer_out(xfer));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		if (fail_count == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// request held until pready is seen high at a rising edge
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk);
		apb.penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		apb.psel <= 1'b0;
		apb.penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			fail_count++;
			complete_run();
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask

	task automatic irqchk(input logic e);
		cyc(2);
		chk({31'h0, irq_line}, {31'h0, e});
	endtask

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task automatic s_reset();
		rdchk(OFF_IRQ, 32'h0000_0000);
		rdchk(OFF_SRC_START, ADDR_RST);
		rdchk(OFF_DST_START, ADDR_RST);
		rdchk(OFF_EVENT, {8'h00, SEL_RST, SEL_RST, 8'h00});
	endtask

	task automatic s_addr();
		wr(OFF_SRC_START, 32'h8000_1234);
		wr(OFF_DST_START, 32'h1fff_0ff0);
		rdchk(OFF_SRC_START, 32'h8000_1234);
		rdchk(OFF_DST_START, 32'h1fff_0ff0);
		chk(src_start, 32'h8000_1234);
		chk(dst_start, 32'h1fff_0ff0);
	endtask

	// boundary selectors: start on 255, abort on 0
	task automatic s_events();
		int s0, a0;
		s0 = starts;
		a0 = aborts;
		wr(OFF_EVENT, 32'h0000_ff1f);
		rdchk(OFF_EVENT, 32'h0000_ff18);
		dcei_xfer_model_inst.raise_irq(8'hff);
		cyc(3);
		chk(starts, s0 + 1);
		chk({31'h0, busy}, 32'h1);
		rdchk(OFF_CHAN_CTRL, 32'h0000_8000);
		dcei_xfer_model_inst.raise_irq(8'h00);
		cyc(3);
		chk(aborts, a0 + 1);
		chk({31'h0, busy}, 32'h0);
		rdchk(OFF_IRQ, 32'h0000_0002);
		wr(OFF_IRQ, 32'h0000_0000);
		wr(OFF_EVENT, 32'h0000_ff00);
		dcei_xfer_model_inst.raise_irq(8'hff);
		dcei_xfer_model_inst.raise_irq(8'h00);
		cyc(3);
		chk(starts, s0 + 1);
		chk(aborts, a0 + 1);
		rdchk(OFF_IRQ, 32'h0000_0000);
		wr(OFF_EVENT, 32'h0000_ff80);
		cyc(3);
		chk(starts, s0 + 2);
		rdchk(OFF_EVENT, 32'h0000_ff00);
		wr(OFF_EVENT, 32'h0000_ff40);
		cyc(3);
		chk(aborts, a0 + 2);
		rdchk(OFF_EVENT, 32'h0000_ff00);
		wr(OFF_IRQ, 32'h0000_0000);
	endtask

	task automatic s_pattern();
		int a0;
		a0 = aborts;
		wr(OFF_CHAN_CTRL, 32'h0000_0001);
		dcei_xfer_model_inst.fire(1);
		cyc(2);
		chk({31'h0, chan_on}, 32'h1);
		chk(aborts, a0);
		wr(OFF_EVENT, 32'h0000_ff20);
		dcei_xfer_model_inst.fire(1);
		cyc(2);
		chk({31'h0, chan_on}, 32'h0);
		chk(aborts, a0 + 1);
		rdchk(OFF_IRQ, 32'h0000_0008);
		wr(OFF_EVENT, 32'h0000_ff00);
		wr(OFF_IRQ, 32'h0000_0000);
	endtask

	// each of nine flag sources in turn (abort flag not fired), masked, enabled, sticky, cleared
	task automatic s_flags();
		logic [7:0] e;
		for (int k = 0; k < 9; k++)
		begin
			e = fexp[k];
			dcei_xfer_model_inst.fire(k);
			cyc(2);
			rdchk(OFF_IRQ, {24'h0, e});
			irqchk(1'b0);
			wr(OFF_IRQ, {8'hff, ~e, 8'hff, e});
			rdchk(OFF_IRQ, {8'h00, ~e, 8'h00, e});
			irqchk(1'b0);
			wr(OFF_IRQ, {8'h00, e, 8'h00, e});
			irqchk(1'b1);
			cyc(4);
			irqchk(1'b1);
			wr(OFF_IRQ, 32'h0000_0000);
			irqchk(1'b0);
		end
	endtask

	task automatic s_unmapped();
		wr(12'h020, 32'hffff_ffff);
		chk({31'h0, err}, 32'h1);
		bus(1'b0, 12'h020, 32'h0000_0000);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0000_0000);
	endtask

	// clock enable low: irq and cell events pass unseen, state holds
	task automatic s_freeze();
		int s0;
		s0 = starts;
		wr(OFF_EVENT, 32'h0000_ff10);
		@(posedge clk);
		ce <= 1'b0;
		dcei_xfer_model_inst.raise_irq(8'hff);
		dcei_xfer_model_inst.fire(2);
		@(posedge clk);
		ce <= 1'b1;
		cyc(3);
		chk(starts, s0);
		rdchk(OFF_IRQ, 32'h0000_0000);
		dcei_xfer_model_inst.raise_irq(8'hff);
		cyc(3);
		chk(starts, s0 + 1);
		wr(OFF_EVENT, 32'h0000_ff00);
	endtask

	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		cyc(4);
		s_reset();
		s_addr();
		s_events();
		s_pattern();
		s_flags();
		s_unmapped();
		s_freeze();
		complete_run();
	end
endmodule

// >>> bench/dcei_xfer_model.sv
// far-side model: interrupt sources and transfer engine status lines
`timescale 1ns/1ns
module dcei_xfer_model
(
	input  wire logic           clk_in,
	output dcei_pkg::dcei_xfer_in_t xfer_out
);
	import dcei_pkg::*;

	// ****************************************************************
	// event sources
	// ****************************************************************
	initial xfer_out = '{src_size: 16'h0010, dst_size: 16'h0020,
		default: '0};

	// number lines are scrambled once valid drops, not left holding
	task automatic raise_irq(input logic [7:0] n);
		@(posedge clk_in);
		xfer_out.irq_num <= n;
		xfer_out.irq_valid <= 1'b1;
		@(posedge clk_in);
		xfer_out.irq_valid <= 1'b0;
		xfer_out.irq_num <= ~n;
	endtask

	task automatic fire(input int k);
		@(posedge clk_in);
		case (k)
			7: xfer_out.src_ptr <= 17'h00010;
			6: xfer_out.src_ptr <= 17'h00008;
			5: xfer_out.dst_ptr <= 17'h00020;
			4: xfer_out.dst_ptr <= 17'h00010;
			3:
			begin
				xfer_out.src_size <= 16'h0000;
				xfer_out.src_ptr <= 17'h10000;
			end
			8:
			begin
				xfer_out.dst_size <= 16'h0000;
				xfer_out.dst_ptr <= 17'h10000;
			end
			2: xfer_out.cell_done <= 1'b1;
			1: xfer_out.pattern_match <= 1'b1;
			default: xfer_out.addr_error <= 1'b1;
		endcase
		@(posedge clk_in);
		xfer_out.cell_done <= 1'b0;
		xfer_out.pattern_match <= 1'b0;
		xfer_out.addr_error <= 1'b0;
		@(posedge clk_in);
		xfer_out.src_ptr <= '0;
		xfer_out.dst_ptr <= '0;
		xfer_out.src_size <= 16'h0010;
		xfer_out.dst_size <= 16'h0020;
	endtask
endmodule

// >>> logic/dcei_pkg.sv
// constants and carrier types for the dma channel event and irq slice
package dcei_pkg;

	// ****************************************************************
	// register offsets (byte addresses on the apb)
	// ****************************************************************
	localparam logic [11:0] OFF_EVENT     = 12'h000;
	localparam logic [11:0] OFF_IRQ       = 12'h004;
	localparam logic [11:0] OFF_SRC_START = 12'h008;
	localparam logic [11:0] OFF_DST_START = 12'h00c;
	localparam logic [11:0] OFF_CHAN_CTRL = 12'h010;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int EV_FORCE_BIT  = 7;
	localparam int EV_ABORT_BIT  = 6;
	localparam int EV_PAT_BIT    = 5;
	localparam int EV_SIRQ_BIT   = 4;
	localparam int EV_AIRQ_BIT   = 3;
	localparam int EV_SSEL_LSB   = 8;
	localparam int EV_ASEL_LSB   = 16;
	localparam int IRQ_IE_LSB    = 16;
	localparam int CTRL_ON_BIT   = 0;
	localparam int CTRL_BUSY_BIT = 15;
	localparam int FL_SRC_DONE   = 7;
	localparam int FL_SRC_HALF   = 6;
	localparam int FL_DST_DONE   = 5;
	localparam int FL_DST_HALF   = 4;
	localparam int FL_BLOCK      = 3;
	localparam int FL_CELL       = 2;
	localparam int FL_ABORT      = 1;
	localparam int FL_ADDR_ERR   = 0;

	// ****************************************************************
	// reset values and sizes
	// ****************************************************************
	localparam logic [7:0]  SEL_RST        = 8'hff;
	localparam logic [7:0]  FLAGS_RST      = 8'h00;
	localparam logic [31:0] ADDR_RST       = 32'h0000_0000;
	localparam logic [16:0] SIZE_ZERO_BYTES = 17'h10000;

	// ****************************************************************
	// carrier types
	// ****************************************************************
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} dcei_apb_req_t;

	typedef struct packed {
		logic [15:0] src_size;
		logic [15:0] dst_size;
		logic [16:0] src_ptr;
		logic [16:0] dst_ptr;
		logic        cell_done;
		logic        pattern_match;
		logic        addr_error;
		logic        irq_valid;
		logic [7:0]  irq_num;
	} dcei_xfer_in_t;

	typedef struct packed {
		logic [7:0]  start_sel;
		logic [7:0]  abort_sel;
		logic        pat_en;
		logic        sirq_en;
		logic        airq_en;
		logic [7:0]  ie;
		logic [7:0]  flags;
		logic [31:0] src_start;
		logic [31:0] dst_start;
		logic        chan_on;
		logic        busy;
		logic        start_pulse;
		logic        abort_pulse;
		logic [4:0]  match_prev;
		logic [31:0] rdata;
		logic        slverr;
	} dcei_state_t;

endpackage

// >>> logic/dcei_top.sv
// dma channel event, irq flag and start address slice with apb registers
`timescale 1ns/1ns
module dcei_top
	import dcei_pkg::*;
(
	input  wire logic                    REF_CLK_IN,
	input  wire logic                    RSTN_IN,
	input  wire logic                    CE_IN,
	input  wire dcei_pkg::dcei_apb_req_t APB_REQ_IN,
	output logic                         PREADY_OUT,
	output logic [31:0]                  PRDATA_OUT,
	output logic                         PSLVERR_OUT,
	input  wire dcei_pkg::dcei_xfer_in_t XFER_IN,
	output logic                         START_OUT,
	output logic                         ABORT_OUT,
	output logic                         BUSY_OUT,
	output logic                         CHANNEL_ON_OUT,
	output logic                         IRQ_OUT,
	output logic [31:0]                  SRC_START_OUT,
	output logic [31:0]                  DST_START_OUT
);
	import dcei_pkg::*;

	// ****************************************************************
	// reset release
	// ****************************************************************
	logic [1:0]  rst_sync;
	logic        rst_n;

	always_ff @(posedge REF_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
			rst_sync <= 2'h0;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	// ****************************************************************
	// event decode
	// ****************************************************************
	dcei_state_t s;
	dcei_state_t next_s;
	logic        setup;
	logic        mapped;
	logic        wr;
	logic        wr_event;
	logic        wr_irq;
	logic [16:0] src_eff;
	logic [16:0] dst_eff;
	logic [4:0]  match_now;
	logic        start_hit;
	logic        abort_hit;
	logic        pat_abort;
	logic        sw_force;
	logic        sw_abort;
	logic        abort_any;
	logic        start_any;
	logic [7:0]  flag_set;
	logic [31:0] read_mux;

	assign setup  = APB_REQ_IN.psel && !APB_REQ_IN.penable;
	assign mapped = APB_REQ_IN.paddr == OFF_EVENT
		|| APB_REQ_IN.paddr == OFF_IRQ
		|| APB_REQ_IN.paddr == OFF_SRC_START
		|| APB_REQ_IN.paddr == OFF_DST_START
		|| APB_REQ_IN.paddr == OFF_CHAN_CTRL;
	assign wr = APB_REQ_IN.psel && APB_REQ_IN.penable
		&& APB_REQ_IN.pwrite && mapped;
	assign wr_event = wr && APB_REQ_IN.paddr == OFF_EVENT;
	assign wr_irq   = wr && APB_REQ_IN.paddr == OFF_IRQ;

	// zero size stands for the full 64 kib range
	assign src_eff = (XFER_IN.src_size == 16'h0000) ? SIZE_ZERO_BYTES
		: {1'b0, XFER_IN.src_size};
	assign dst_eff = (XFER_IN.dst_size == 16'h0000) ? SIZE_ZERO_BYTES
		: {1'b0, XFER_IN.dst_size};

	// flags fire on the edge of a match so a cleared flag stays clear
	// while the pointer rests on the same value
	always_comb
	begin
		match_now[4] = XFER_IN.src_ptr == src_eff;
		match_now[3] = XFER_IN.src_ptr == (src_eff >> 1);
		match_now[2] = XFER_IN.dst_ptr == dst_eff;
		match_now[1] = XFER_IN.dst_ptr == (dst_eff >> 1);
		if (src_eff >= dst_eff)
			match_now[0] = match_now[4];
		else
			match_now[0] = match_now[2];
	end

	assign start_hit = XFER_IN.irq_valid && s.sirq_en
		&& XFER_IN.irq_num == s.start_sel;
	assign abort_hit = XFER_IN.irq_valid && s.airq_en
		&& XFER_IN.irq_num == s.abort_sel;
	assign pat_abort = XFER_IN.pattern_match && s.pat_en;
	assign sw_force  = wr_event && APB_REQ_IN.pwdata[EV_FORCE_BIT];
	assign sw_abort  = wr_event && APB_REQ_IN.pwdata[EV_ABORT_BIT];
	assign abort_any = sw_abort || abort_hit || pat_abort;
	// abort outranks a start in the same cycle
	assign start_any = (sw_force || start_hit) && !abort_any;

	always_comb
	begin
		flag_set = 8'h00;
		flag_set[FL_SRC_DONE] = match_now[4] && !s.match_prev[4];
		flag_set[FL_SRC_HALF] = match_now[3] && !s.match_prev[3];
		flag_set[FL_DST_DONE] = match_now[2] && !s.match_prev[2];
		flag_set[FL_DST_HALF] = match_now[1] && !s.match_prev[1];
		flag_set[FL_BLOCK]    = (match_now[0] && !s.match_prev[0])
			|| XFER_IN.pattern_match;
		flag_set[FL_CELL]     = XFER_IN.cell_done;
		flag_set[FL_ABORT]    = abort_hit;
		flag_set[FL_ADDR_ERR] = XFER_IN.addr_error;
	end

	// ****************************************************************
	// register read view
	// ****************************************************************
	always_comb
	begin
		read_mux = 32'h0000_0000;
		unique case (APB_REQ_IN.paddr)
			OFF_EVENT:
			begin
				// strobes and bits 2..0 always read zero
				read_mux[EV_ASEL_LSB +: 8] = s.abort_sel;
				read_mux[EV_SSEL_LSB +: 8] = s.start_sel;
				read_mux[EV_PAT_BIT]  = s.pat_en;
				read_mux[EV_SIRQ_BIT] = s.sirq_en;
				read_mux[EV_AIRQ_BIT] = s.airq_en;
			end
			OFF_IRQ:
			begin
				read_mux[IRQ_IE_LSB +: 8] = s.ie;
				read_mux[7:0] = s.flags;
			end
			OFF_SRC_START: read_mux = s.src_start;
			OFF_DST_START: read_mux = s.dst_start;
			OFF_CHAN_CTRL:
			begin
				read_mux[CTRL_BUSY_BIT] = s.busy;
				read_mux[CTRL_ON_BIT]   = s.chan_on;
			end
			default: read_mux = 32'h0000_0000;
		endcase
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb
	begin
		next_s = s;
		next_s.start_pulse = start_any;
		next_s.abort_pulse = abort_any;
		next_s.match_prev  = match_now;
		if (setup)
		begin
			next_s.rdata  = APB_REQ_IN.pwrite ? 32'h0000_0000 : read_mux;
			next_s.slverr = !mapped;
		end
		if (wr_event)
		begin
			next_s.abort_sel = APB_REQ_IN.pwdata[EV_ASEL_LSB +: 8];
			next_s.start_sel = APB_REQ_IN.pwdata[EV_SSEL_LSB +: 8];
			next_s.pat_en    = APB_REQ_IN.pwdata[EV_PAT_BIT];
			next_s.sirq_en   = APB_REQ_IN.pwdata[EV_SIRQ_BIT];
			next_s.airq_en   = APB_REQ_IN.pwdata[EV_AIRQ_BIT];
		end
		if (wr && APB_REQ_IN.paddr == OFF_SRC_START)
			next_s.src_start = APB_REQ_IN.pwdata;
		if (wr && APB_REQ_IN.paddr == OFF_DST_START)
			next_s.dst_start = APB_REQ_IN.pwdata;
		if (wr && APB_REQ_IN.paddr == OFF_CHAN_CTRL)
			next_s.chan_on = APB_REQ_IN.pwdata[CTRL_ON_BIT];
		// hardware clear of channel_on wins over a software set
		if (pat_abort)
			next_s.chan_on = 1'b0;
		if (wr_irq)
		begin
			next_s.ie    = APB_REQ_IN.pwdata[IRQ_IE_LSB +: 8];
			next_s.flags = APB_REQ_IN.pwdata[7:0];
		end
		// a flag event in the clearing cycle still lands
		next_s.flags = next_s.flags | flag_set;
		if (abort_any)
			next_s.busy = 1'b0;
		else if (start_any)
			next_s.busy = 1'b1;
		else if (match_now[0] && !s.match_prev[0])
			next_s.busy = 1'b0;
	end

	always_ff @(posedge REF_CLK_IN or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s            <= '0;
			s.start_sel  <= SEL_RST;
			s.abort_sel  <= SEL_RST;
			s.flags      <= FLAGS_RST;
			s.src_start  <= ADDR_RST;
			s.dst_start  <= ADDR_RST;
			s.match_prev <= 5'h1f;
		end
		else if (CE_IN)
			s <= next_s;
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	// one wait-free access phase: read data was captured in setup
	assign PREADY_OUT     = 1'b1;
	assign PRDATA_OUT     = s.rdata;
	assign PSLVERR_OUT    = s.slverr && APB_REQ_IN.psel
		&& APB_REQ_IN.penable;
	assign START_OUT      = s.start_pulse;
	assign ABORT_OUT      = s.abort_pulse;
	assign BUSY_OUT       = s.busy;
	assign CHANNEL_ON_OUT = s.chan_on;
	assign IRQ_OUT        = |(s.flags & s.ie);
	assign SRC_START_OUT  = s.src_start;
	assign DST_START_OUT  = s.dst_start;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge REF_CLK_IN); endclocking
	default disable iff (!rst_n || !CE_IN);

	sequence event_read_s;
		setup && !APB_REQ_IN.pwrite && APB_REQ_IN.paddr == OFF_EVENT;
	endsequence
	sequence irq_read_s;
		setup && !APB_REQ_IN.pwrite && APB_REQ_IN.paddr == OFF_IRQ;
	endsequence

	force_start_a: assert property (
		sw_force |=> START_OUT && BUSY_OUT || ABORT_OUT && !START_OUT)
		else $error("force strobe did not start");
	sw_abort_a: assert property (
		sw_abort |=> ABORT_OUT && !BUSY_OUT && !START_OUT)
		else $error("abort strobe did not abort");
	strobe_read_a: assert property (
		event_read_s |=> PRDATA_OUT[7:6] == 2'h0
			&& PRDATA_OUT[2:0] == 3'h0)
		else $error("event register reserved bits nonzero");
	pat_abort_a: assert property (
		XFER_IN.pattern_match && s.pat_en |=> ABORT_OUT && !CHANNEL_ON_OUT
			&& s.flags[FL_BLOCK])
		else $error("pattern abort missed");
	irq_start_a: assert property (
		start_hit && !abort_any |=> START_OUT && BUSY_OUT)
		else $error("start irq ignored");
	irq_ignore_a: assert property (
		!s.sirq_en && !sw_force |=> !START_OUT)
		else $error("start without cause");
	irq_abort_a: assert property (
		abort_hit |=> ABORT_OUT && s.flags[FL_ABORT])
		else $error("abort irq did not abort and flag");
	flag_sticky_a: assert property (
		!wr_irq |=> (s.flags & $past(s.flags)) == $past(s.flags))
		else $error("flag dropped without clear");
	addr_err_a: assert property (
		XFER_IN.addr_error |=> s.flags[FL_ADDR_ERR] && (IRQ_OUT
			|| !s.ie[FL_ADDR_ERR]))
		else $error("address error not flagged");
	irq_gaps_a: assert property (
		irq_read_s |=> PRDATA_OUT[31:24] == 8'h00
			&& PRDATA_OUT[15:8] == 8'h00)
		else $error("irq register reserved bits nonzero");
	cell_flag_a: assert property (
		XFER_IN.cell_done ##1 !wr_irq [*2] |-> s.flags[FL_CELL])
		else $error("cell flag lost");
	pat_off_a: assert property (
		XFER_IN.pattern_match && !s.pat_en && !sw_abort && !abort_hit
			|=> !ABORT_OUT)
		else $error("pattern abort while disabled");
	airq_off_a: assert property (
		XFER_IN.irq_valid && !s.airq_en && !sw_abort && !pat_abort
			|=> !ABORT_OUT)
		else $error("abort irq acted while disabled");
	src_done_a: assert property (
		XFER_IN.src_ptr == src_eff && !s.match_prev[4]
			|=> s.flags[FL_SRC_DONE])
		else $error("source done flag missed");
	src_half_a: assert property (
		XFER_IN.src_ptr == (src_eff >> 1) && !s.match_prev[3]
			|=> s.flags[FL_SRC_HALF])
		else $error("source half flag missed");
	dst_done_a: assert property (
		XFER_IN.dst_ptr == dst_eff && !s.match_prev[2]
			|=> s.flags[FL_DST_DONE])
		else $error("destination done flag missed");
	dst_half_a: assert property (
		XFER_IN.dst_ptr == (dst_eff >> 1) && !s.match_prev[1]
			|=> s.flags[FL_DST_HALF])
		else $error("destination half flag missed");
	zero_size_a: assert property (
		XFER_IN.src_size == 16'h0000 && !s.match_prev[4]
			&& XFER_IN.src_ptr == SIZE_ZERO_BYTES
			|=> s.flags[FL_SRC_DONE])
		else $error("zero size not taken as full range");
	block_pat_a: assert property (
		XFER_IN.pattern_match |=> s.flags[FL_BLOCK])
		else $error("pattern match did not flag block");
	abort_wins_a: assert property (
		abort_any |=> !START_OUT && !BUSY_OUT)
		else $error("start survived an abort");
	busy_start_a: assert property (
		START_OUT |-> BUSY_OUT)
		else $error("start without busy");
	chan_keep_a: assert property (
		!pat_abort && !(wr && APB_REQ_IN.paddr == OFF_CHAN_CTRL)
			|=> $stable(CHANNEL_ON_OUT))
		else $error("channel on changed without cause");

endmodule
